//--- jfcm_pkg.sv
package jfcm_pkg;

  localparam int  JFCM_SYNC_STAGES = 3;
  localparam logic [1:0] JFCM_RISE_LIMIT = 2'h2;
  localparam logic [1:0] JFCM_RISE_RST   = 2'h0;
  localparam logic       JFCM_FLAG_RST   = 1'h0;
  localparam logic       JFCM_PIN_RST    = 1'h1;

  typedef enum logic [1:0] {
    JFCM_ST_WAIT = 2'b00,
    JFCM_ST_ACT  = 2'b01,
    JFCM_ST_DONE = 2'b10
  } jfcm_state_t;

  typedef struct packed {
    logic tms;
    logic test;
    logic fuse_blown;
  } jfcm_pins_t;

endpackage

//--- jfcm_sync.sv
`timescale 1ns/1ps
module jfcm_sync
  import jfcm_pkg::*;
#(
  parameter int          WIDTH     = 3,
  parameter logic [2:0]  RST_VALUE = 3'h7
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] filt_r;

  // Stage1 only feeds stage2; glitches filtered by stage2/stage3 agreement
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          stage1_r[gi] <= RST_VALUE[gi];
          stage2_r[gi] <= RST_VALUE[gi];
          stage3_r[gi] <= RST_VALUE[gi];
          filt_r[gi]   <= RST_VALUE[gi];
        end else begin
          stage1_r[gi] <= async_i[gi];
          stage2_r[gi] <= stage1_r[gi];
          stage3_r[gi] <= stage2_r[gi];
          if (stage2_r[gi] == stage3_r[gi]) begin
            filt_r[gi] <= stage3_r[gi];
          end
        end
      end
    end
  endgenerate

  assign sync_o = filt_r;

endmodule

//--- jfcm_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Where the fuse sits on the test pin, its continuity check runs on the first port access after power-on.
// - Check mode starts at the first falling edge of the mode-select pin after power-up.
// - If the mode-select pin is low as power comes up, check mode starts with no edge needed.
// - Check mode ends at the second rising edge of the mode-select pin after power-up.
// - Once ended, check mode stays off whatever the mode-select pin does until the next power-on reset.
// - Driving the test pin low again ends check mode and stops the sense current.
// - The check current flows only while check mode is on and the mode-select pin is low.
// - With the fuse blown, code and data memory access through the port is blocked.
module jfcm_top
  import jfcm_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic tms_i,
  input  wire logic test_i,
  input  wire logic fuse_blown_i,
  output logic      check_current_o,
  output logic      check_active_o,
  output logic      mem_access_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  jfcm_pins_t pins_raw;
  jfcm_pins_t pins_s;
  logic [2:0] pins_vec;

  assign pins_raw = '{tms: tms_i, test: test_i, fuse_blown: fuse_blown_i};

  // Reset value idles tms high, test low, fuse treated as blown (safe side)
  jfcm_sync #(
    .WIDTH     (3),
    .RST_VALUE (3'h5)
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (pins_raw),
    .sync_o  (pins_vec)
  );

  assign pins_s = pins_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Power-up sampling of the select pin; first edge after release decides
  logic        started_r;
  logic        tms_prev_r;
  logic        tms_fall;
  logic        tms_rise;
  logic [1:0]  rise_cnt_r;
  logic [1:0]  rise_cnt_nxt;
  jfcm_state_t state_r;
  jfcm_state_t state_nxt;

  assign tms_fall = started_r && tms_prev_r && !pins_s.tms;
  assign tms_rise = started_r && !tms_prev_r && pins_s.tms;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      started_r  <= 1'b0;
      tms_prev_r <= JFCM_PIN_RST;
    end else begin
      started_r  <= 1'b1;
      tms_prev_r <= pins_s.tms;
    end
  end

  // Saturates at the limit so later rises cannot wrap the count
  always_comb begin
    rise_cnt_nxt = rise_cnt_r;
    if (tms_rise && rise_cnt_r != JFCM_RISE_LIMIT) begin
      rise_cnt_nxt = rise_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_cnt_r <= JFCM_RISE_RST;
    end else begin
      rise_cnt_r <= rise_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      JFCM_ST_WAIT: begin
        // Edge tracker resets idle-high, so a pin held low through power-up reads as a fall
        if (tms_fall) begin
          state_nxt = JFCM_ST_ACT;
        end
        if (rise_cnt_nxt == JFCM_RISE_LIMIT) begin
          state_nxt = JFCM_ST_DONE;
        end
      end
      JFCM_ST_ACT: begin
        if (rise_cnt_nxt == JFCM_RISE_LIMIT) begin
          state_nxt = JFCM_ST_DONE;
        end else if (tms_fall && !pins_s.test && tms_prev_r) begin
          state_nxt = JFCM_ST_ACT;
        end
      end
      JFCM_ST_DONE: begin
        state_nxt = JFCM_ST_DONE;
      end
      default: begin
        state_nxt = JFCM_ST_DONE;
      end
    endcase
  end

  // Falling test pin ends the session; held in DONE till power-on
  // Only an active mode is ended; a fall while waiting changes nothing
  logic test_prev_r;
  logic test_fall;
  assign test_fall = started_r && test_prev_r && !pins_s.test;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      test_prev_r <= 1'b0;
    end else begin
      test_prev_r <= pins_s.test;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= JFCM_ST_WAIT;
    end else if (test_fall && state_r == JFCM_ST_ACT) begin
      // Test fall wins over any select edge in the same cycle
      state_r <= JFCM_ST_DONE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs registered; one cycle behind state
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      check_current_o <= JFCM_FLAG_RST;
      check_active_o  <= JFCM_FLAG_RST;
      mem_access_en_o <= JFCM_FLAG_RST;
    end else begin
      check_active_o  <= (state_r == JFCM_ST_ACT);
      check_current_o <= (state_r == JFCM_ST_ACT) && !pins_s.tms;
      // Filtered pin only; a short glitch cannot open access
      mem_access_en_o <= !pins_s.fuse_blown;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks watch filtered pins, so registered outputs are expected one cycle later
  current_needs_mode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    check_current_o |-> $past(state_r == JFCM_ST_ACT) && $past(!pins_s.tms))
    else $error("check current without active mode and low select");

  done_is_sticky_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_r == JFCM_ST_DONE |=> state_r == JFCM_ST_DONE)
    else $error("done state left before reset");

  fall_activates_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_r == JFCM_ST_WAIT && tms_fall && rise_cnt_nxt != JFCM_RISE_LIMIT |=> state_r == JFCM_ST_ACT)
    else $error("falling select edge did not activate");

  second_rise_ends_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    tms_rise && rise_cnt_r == 2'h1 |=> state_r == JFCM_ST_DONE)
    else $error("second rising edge did not end mode");

  low_at_start_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_r == JFCM_ST_WAIT && !pins_s.tms |=> state_r == JFCM_ST_ACT)
    else $error("low select at power-up did not activate");

  test_low_ends_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_r == JFCM_ST_ACT && test_fall |=> state_r == JFCM_ST_DONE ##1 !check_current_o)
    else $error("test pin fall did not end mode");

  fuse_blocks_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pins_s.fuse_blown |=> !mem_access_en_o)
    else $error("memory access open with blown fuse");

  access_starts_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(check_active_o) |-> $past(tms_fall, 2))
    else $error("check mode started without a port access");

  counter_bound_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rise_cnt_r <= JFCM_RISE_LIMIT)
    else $error("rise counter past limit");

  first_edge_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !started_r |-> state_r == JFCM_ST_WAIT && rise_cnt_r == JFCM_RISE_RST)
    else $error("tracking not cleared after power-on");

  done_quiet_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_r == JFCM_ST_DONE |=> !check_current_o && !check_active_o)
    else $error("outputs active after mode ended");

  select_high_quiet_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pins_s.tms |=> !check_current_o)
    else $error("check current with select high");

  fuse_open_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !pins_s.fuse_blown |=> mem_access_en_o)
    else $error("memory access closed with intact fuse");

  rise_counted_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    tms_rise && rise_cnt_r == JFCM_RISE_RST |=> rise_cnt_r == 2'h1)
    else $error("first rising edge not counted");

  current_on_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) check_current_o);
  full_cycle_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    state_r == JFCM_ST_ACT ##[1:200] state_r == JFCM_ST_DONE);
  test_end_c:   cover property (@(posedge clock_i) disable iff (!rst_n_i)
    state_r == JFCM_ST_ACT && test_fall);
  held_low_c:   cover property (@(posedge clock_i) disable iff (!rst_n_i)
    state_r == JFCM_ST_WAIT && !pins_s.tms);
  rise_end_c:   cover property (@(posedge clock_i) disable iff (!rst_n_i)
    state_r == JFCM_ST_ACT && tms_rise && rise_cnt_r == 2'h1);

endmodule

//--- jfcm_tool_model.sv
`timescale 1ns/1ps
module jfcm_tool_model (
  input  wire logic clock_i,
  input  wire logic tms_req_i,
  input  wire logic test_req_i,
  output logic      tms_o,
  output logic      test_o
);
  ////////////////////////////////////////////////////////////////
  // Idle with select high so no check current is drawn
  initial tms_o = 1'b1;
  initial test_o = 1'b0;
  ////////////////////////////////////////////////////////////////
  // Pins move only just after the falling edge
  always @(negedge clock_i) begin
    tms_o <= tms_req_i;
    test_o <= test_req_i;
  end
endmodule

//--- jfcm_top_test.sv
`timescale 1ns/1ps
module jfcm_top_test;
  import jfcm_pkg::*;
  logic        clock_i      = 1'b0;
  logic        rst_n_i      = 1'b0;
  logic        tms_req      = 1'b0;
  logic        test_req     = 1'b1;
  logic        fuse_blown_i = 1'b0;
  logic        tms_pin;
  logic        test_pin;
  logic        check_current_o;
  logic        check_active_o;
  logic        mem_access_en_o;
  logic [3:0]  st;
  logic        ptms;
  logic        ptest;
  logic [31:0] r;
  int          mismatches   = 0;
  int          num_checks   = 0;
  int          cycles       = 0;
  int          seed         = 32'h0ff90bbc;

  always #10 clock_i = ~clock_i;

  jfcm_tool_model i_tool (.clock_i(clock_i), .tms_req_i(tms_req), .test_req_i(test_req),
                          .tms_o(tms_pin), .test_o(test_pin));
  jfcm_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .tms_i(tms_pin), .test_i(test_pin),
                  .fuse_blown_i(fuse_blown_i), .check_current_o(check_current_o),
                  .check_active_o(check_active_o), .mem_access_en_o(mem_access_en_o));

  ////////////////////////////////////////////////////////////////
  // State is {disabled, active, rise count}
  function automatic logic [3:0] ref_next(input logic [3:0] s, input logic tms, input logic pt,
                                          input logic test, input logic pte);
    if (s[3]) return s;
    if (s[2] && pte && !test) return 4'h8;
    if (pt && !tms) s[2] = 1'b1;
    if (!pt && tms) s[1:0] = s[1:0] + 2'h1;
    if (s[1:0] == 2'h2) return 4'ha;
    return s;
  endfunction

  task automatic check(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Wait covers tool delay plus synchroniser and state latency
  task automatic step(input logic tms, input logic test, input logic fuse);
    @(negedge clock_i);
    tms_req <= tms;
    test_req <= test;
    fuse_blown_i <= fuse;
    st = ref_next(st, tms, ptms, test, ptest);
    ptms = tms;
    ptest = test;
    repeat (12) @(negedge clock_i);
    check(check_active_o, st[2]);
    check(check_current_o, st[2] & ~tms);
    check(mem_access_en_o, ~fuse);
  endtask

  // Synchroniser wakes with select high, so a low pin looks like a fall
  task automatic power_up(input logic tms);
    @(negedge clock_i);
    rst_n_i <= 1'b0;
    tms_req <= tms;
    test_req <= 1'b1;
    repeat (12) @(negedge clock_i);
    check(check_active_o, 1'b0);
    rst_n_i <= 1'b1;
    st = ref_next(4'h0, tms, 1'b1, 1'b1, 1'b0);
    ptms = tms;
    ptest = 1'b1;
    repeat (12) @(negedge clock_i);
    check(check_active_o, st[2]);
  endtask

  ////////////////////////////////////////////////////////////////
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    for (int p = 0; p < 6; p++) begin
      power_up(p[0]);
      if (p < 2) begin
        for (int k = 0; k < 6; k++) begin
          step(~k[0], 1'b1, k[1]);
        end
      end
      for (int s = 0; s < 14; s++) begin
        r = $random(seed);
        if (r[3:0] == 4'h0) step(ptms, 1'b0, r[4]);
        else step(r[5], ptest, r[4]);
      end
      $display("power cycle %0d finished", p);
    end
    final_report();
  end
endmodule
